// ---- logic/sph_pkg.sv ----
/*
  Constants for the serial pause-control block.
  Assumes a 20 MHz system clock sampling the serial pins.
*/
package sph_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [7:0] OPCODE_RESET = 8'h00;
  localparam logic [2:0] BITCNT_RESET = 3'h0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [14:0] ADDR_MASK = 15'h7fff;
  typedef enum logic [1:0] {SPH_IDLE, SPH_CMD, SPH_ADDR, SPH_DATA} sph_phase_t;
endpackage

// ---- logic/sph_spi_hold.sv ----
/*
  Serial interface front end with pause control: tracks opcode, address
  and data bytes and freezes them while the pause pin is low.
  Assumes pins are asynchronous to clk; the memory core sits on mem*.
*/
`timescale 1ns/1ns
// How it works
// R1: pause honoured only selected, sequence in progress
// R2: pause keeps sequence progress intact
// R3: master lowers pause only while clock low
// R4: master keeps select low during pause
// R5: data input ignored while paused
// R6: data output floats while paused
// R7: master releases pause only while clock low
// R8: clock may toggle during pause harmlessly
// R9: counters and shifters frozen while paused
module sph_spi_hold (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  input wire logic [7:0] memRdData,
  output logic so,
  output logic soOe,
  output logic [14:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrStrobe,
  output logic [7:0] opcode,
  output logic paused
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] csS;
    logic [1:0] sckS;
    logic [1:0] siS;
    logic [1:0] holdS;
    logic sckPrev;
    logic pause;
    sph_pkg::sph_phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic addrByte;
    logic [7:0] shiftOut;
    logic soBit;
    logic soEn;
    logic wrStrobe;
    logic [7:0] wrData;
  } sph_state_t;

  sph_state_t st;
  sph_state_t next_st;

  logic csLow;
  logic sckLow;
  logic sckRise;
  logic sckFall;
  logic inSeq;
  logic siBit;
  logic [7:0] inByte;

  always_comb begin
    csLow = ~st.csS[1];
    sckLow = ~st.sckS[1];
    sckRise = st.sckS[1] & ~st.sckPrev;
    sckFall = ~st.sckS[1] & st.sckPrev;
    siBit = st.siS[1];
    inByte = {st.shiftIn[6:0], siBit};
    inSeq = st.phase != sph_pkg::SPH_IDLE;
  end

  always_comb begin
    next_st = st;
    next_st.csS = {st.csS[0], csN};
    next_st.sckS = {st.sckS[0], sck};
    next_st.siS = {st.siS[0], si};
    next_st.holdS = {st.holdS[0], holdN};
    // R8: edge tracking runs during pause
    next_st.sckPrev = st.sckS[1];
    next_st.wrStrobe = 1'b0;
    // burst address moves once the strobed byte has been taken
    if (st.wrStrobe)
      next_st.addr = {1'b0, st.addr[14:0] + 15'h0001};
    if (!csLow) begin
      // deselect ends the sequence and any pause
      next_st.phase = sph_pkg::SPH_IDLE;
      next_st.pause = 1'b0;
      next_st.bitCnt = sph_pkg::BITCNT_RESET;
      next_st.addrByte = 1'b0;
      next_st.soEn = 1'b0;
    end else begin
      if (st.phase == sph_pkg::SPH_IDLE)
        next_st.phase = sph_pkg::SPH_CMD;
      // R1: pause while selected
      // pause changes are taken only when the clock is low
      if (sckLow && inSeq)
        next_st.pause = ~st.holdS[1];
      // R9: frozen when paused
      if (!st.pause && sckRise && st.phase != sph_pkg::SPH_IDLE) begin
        // R5: input only when running
        next_st.shiftIn = inByte;
        next_st.bitCnt = st.bitCnt + 3'h1;
        if (st.bitCnt == 3'h7) begin
          unique case (st.phase)
            sph_pkg::SPH_CMD: begin
              next_st.opcode = inByte;
              next_st.phase = sph_pkg::SPH_ADDR;
            end
            sph_pkg::SPH_ADDR: begin
              next_st.addrByte = 1'b1;
              if (st.addrByte) begin
                next_st.addr = {st.addr[7:0], inByte};
                next_st.phase = sph_pkg::SPH_DATA;
              end else begin
                next_st.addr = {st.addr[7:0], inByte};
              end
            end
            sph_pkg::SPH_DATA: begin
              next_st.wrData = inByte;
              next_st.wrStrobe = 1'b1;
            end
            default: ;
          endcase
        end
      end
      // R2: output resumes in place
      if (!st.pause && sckFall && st.phase == sph_pkg::SPH_DATA) begin
        if (st.bitCnt == 3'h0)
          next_st.shiftOut = memRdData;
        next_st.soBit = (st.bitCnt == 3'h0) ? memRdData[7] : st.shiftOut[7];
        if (st.bitCnt != 3'h0)
          next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
        else
          next_st.shiftOut = {memRdData[6:0], 1'b0};
        next_st.soEn = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.csS <= 2'h3;
      st.holdS <= 2'h3;
      st.opcode <= sph_pkg::OPCODE_RESET;
      st.addr <= sph_pkg::ADDR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // R6: float output when paused
  assign soOe = st.soEn & ~st.pause & csLow;
  assign so = st.soBit;
  assign memAddr = st.addr[14:0] & sph_pkg::ADDR_MASK;
  assign memWrData = st.wrData;
  assign memWrStrobe = st.wrStrobe;
  assign opcode = st.opcode;
  assign paused = st.pause;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_pauseFloat;
    @(posedge clk) disable iff (rst) st.pause |-> !soOe;
  endproperty
  a_pauseFloat: assert property (p_pauseFloat) // R6
    else $error("output driven while paused");

  property p_frozenCnt;
    @(posedge clk) disable iff (rst)
      (st.pause && csLow) ##1 (st.pause && csLow) |->
        $stable(st.bitCnt) && $stable(st.shiftIn);
  endproperty
  a_frozenCnt: assert property (p_frozenCnt) // R9
    else $error("bit counter moved while paused");

  property p_frozenAddr;
    @(posedge clk) disable iff (rst)
      st.pause ##1 st.pause |-> $stable(st.addr) && $stable(st.phase);
  endproperty
  a_frozenAddr: assert property (p_frozenAddr) // R2
    else $error("address or phase moved while paused");

  property p_noWrite;
    @(posedge clk) disable iff (rst) st.pause |=> !memWrStrobe;
  endproperty
  a_noWrite: assert property (p_noWrite) // R5
    else $error("write strobe while paused");

  property p_pauseSelected;
    @(posedge clk) disable iff (rst) !csLow |=> !st.pause;
  endproperty
  a_pauseSelected: assert property (p_pauseSelected) // R1
    else $error("pause set while deselected");

  property p_enterLow;
    @(posedge clk) disable iff (rst)
      $rose(st.pause) |-> $past(!st.sckS[1] && !st.holdS[1]);
  endproperty
  a_enterLow: assert property (p_enterLow) // R3
    else $error("pause entered with clock high");

  property p_holdOpcode;
    @(posedge clk) disable iff (rst)
      st.pause ##1 st.pause |-> $stable(opcode) && $stable(st.shiftOut);
  endproperty
  a_holdOpcode: assert property (p_holdOpcode) // R2
    else $error("opcode or output shifter moved while paused");

  property p_idleNoPause;
    @(posedge clk) disable iff (rst) st.phase == sph_pkg::SPH_IDLE |-> !st.pause;
  endproperty
  a_idleNoPause: assert property (p_idleNoPause) // R1
    else $error("pause outside a sequence");

  c_pause: cover property (@(posedge clk) disable iff (rst) $rose(st.pause));
  c_resume: cover property (@(posedge clk) disable iff (rst) $fell(st.pause));
  c_pauseData: cover property (@(posedge clk) disable iff (rst)
    st.pause && st.phase == sph_pkg::SPH_DATA);

endmodule // sph_spi_hold

// ---- bench/sph_spi_master.sv ----
/*
  SPI master model: drives select, clock, data in and pause.
  Assumes clk is the bench clock; sck idles low, 8 clk a period.
*/
`timescale 1ns/1ns
module sph_spi_master (
  input wire logic clk,
  input wire logic soLine,
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN
);
  logic [7:0] rx;
  initial begin
    rx = 8'h00;
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      si = v[i];
      step(4);
      sck = 1'b1;
      // sample the line on the rising clock, not while paused
      if (holdN) rx = {rx[6:0], soLine};
      step(4);
      sck = 1'b0;
    end
  endtask
  // select held through pauses; si toggles on every select change
  task automatic select(input logic s);
    step(2);
    csN = ~s;
    si = ~si;
  endtask
  // pause changes only while sck low
  task automatic pause(input logic p);
    step(2);
    holdN = ~p;
  endtask
endmodule // sph_spi_master

// ---- bench/test_sph_spi_hold.sv ----
/*
  Bench for the pause-control serial front end.
  Assumes the master model and a 50 ns clk.
*/
`timescale 1ns/1ns
module test_sph_spi_hold;
  logic clk, rst, csN, sck, si, holdN, so, soOe, memWrStrobe, paused;
  logic [14:0] memAddr;
  logic [7:0] memRdData, memWrData, opcode;
  logic soLine;
  logic [14:0] wrAddr;
  logic [15:0] expAddr, nextAddr;
  int fail_count = 0;
  int total_checks = 0;
  int strobes = 0;
  // opcode, address, data
  logic [31:0] rows [3] = '{32'h02_0000_5a, 32'h03_ffff_a5, 32'h02_8001_ff};
  sph_spi_master sph_spi_master_i (.clk(clk), .soLine(soLine), .csN(csN),
    .sck(sck), .si(si), .holdN(holdN));
  sph_spi_hold sph_spi_hold_i (.clk(clk), .rst(rst), .csN(csN), .sck(sck),
    .si(si), .holdN(holdN), .memRdData(memRdData), .so(so), .soOe(soOe),
    .memAddr(memAddr), .memWrData(memWrData), .memWrStrobe(memWrStrobe),
    .opcode(opcode), .paused(paused));
  // released output line is pulled high
  assign soLine = soOe ? so : 1'b1;
  // memory core model: read byte follows the address
  assign memRdData = memAddr[7:0] ^ 8'h3c;
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (memWrStrobe === 1'b1) begin
      strobes++;
      wrAddr = memAddr;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #5 rst = 1'b0;
    sph_spi_master_i.step(4);
    foreach (rows[k]) begin
      sph_spi_master_i.select(1'b1);
      sph_spi_master_i.shift(16'(rows[k][31:24]), 8);
      sph_spi_master_i.step(4);
      chk("opcode", 16'(rows[k][31:24]), 16'(opcode));
      sph_spi_master_i.shift(rows[k][23:8], 16);
      sph_spi_master_i.step(4);
      expAddr = rows[k][23:8] & sph_pkg::ADDR_MASK;
      nextAddr = (expAddr + 16'h0001) & sph_pkg::ADDR_MASK;
      chk("memAddr", expAddr, 16'(memAddr));
      sph_spi_master_i.shift(16'(rows[k][7:0]), 8);
      sph_spi_master_i.step(4);
      chk("memWrData", 16'(rows[k][7:0]), 16'(memWrData));
      chk("strobes", 16'(k + 1), 16'(strobes));
      chk("wrAddr", expAddr, 16'(wrAddr));
      chk("memAddr", nextAddr, 16'(memAddr));
      chk("so", 16'(expAddr[7:0] ^ 8'h3c), 16'(sph_spi_master_i.rx));
      sph_spi_master_i.select(1'b0);
    end
    sph_spi_master_i.pause(1'b1);
    sph_spi_master_i.step(6);
    chk("paused", 16'h0, 16'(paused));
    sph_spi_master_i.pause(1'b0);
    sph_spi_master_i.select(1'b1);
    sph_spi_master_i.shift(16'h0002, 8);
    sph_spi_master_i.shift(16'h0123, 12);
    sph_spi_master_i.pause(1'b1);
    sph_spi_master_i.step(6);
    chk("paused", 16'h1, 16'(paused));
    chk("soOe", 16'h0, 16'(soOe));
    sph_spi_master_i.shift(16'h00a5, 8);
    sph_spi_master_i.pause(1'b0);
    sph_spi_master_i.step(6);
    chk("paused", 16'h0, 16'(paused));
    sph_spi_master_i.shift(16'h0004, 4);
    sph_spi_master_i.step(4);
    chk("memAddr", 16'h1234, 16'(memAddr));
    sph_spi_master_i.shift(16'h0006, 3);
    sph_spi_master_i.pause(1'b1);
    sph_spi_master_i.step(6);
    chk("soOe", 16'h0, 16'(soOe));
    sph_spi_master_i.shift(16'h00f0, 8);
    sph_spi_master_i.pause(1'b0);
    sph_spi_master_i.step(6);
    chk("soOe", 16'h1, 16'(soOe));
    sph_spi_master_i.shift(16'h0003, 5);
    sph_spi_master_i.step(4);
    chk("memWrData", 16'h00c3, 16'(memWrData));
    chk("so", 16'(8'h34 ^ 8'h3c), 16'(sph_spi_master_i.rx));
    chk("strobes", 16'h4, 16'(strobes));
    sph_spi_master_i.pause(1'b1);
    sph_spi_master_i.step(6);
    rst = 1'b1;
    sph_spi_master_i.step(2);
    chk("paused", 16'h0, 16'(paused));
    chk("soOe", 16'h0, 16'(soOe));
    sph_spi_master_i.pause(1'b0);
    sph_spi_master_i.select(1'b0);
    rst = 1'b0;
    sph_spi_master_i.step(4);
    chk("paused", 16'h0, 16'(paused));
    sph_spi_master_i.select(1'b1);
    sph_spi_master_i.shift(16'h0003, 8);
    sph_spi_master_i.step(4);
    chk("opcode", 16'h0003, 16'(opcode));
    sph_spi_master_i.select(1'b0);
    tally_and_finish();
  end
endmodule // test_sph_spi_hold
